// file: verilog/ebics_params.svh
// constants for the external bus chip select assignment block
`ifndef EBICS_PARAMS_SVH
`define EBICS_PARAMS_SVH
`define EBICS_BASE_ADDR      32'hFFFFFF60
`define EBICS_OFF_ASSIGN     8'h00
`define EBICS_OFF_CONFIG     8'h04
`define EBICS_OFF_RSVD0      8'h08
`define EBICS_OFF_RSVD1      8'h0C
`define EBICS_OFF_BOOT       8'h10
`define EBICS_BIT_CS0        0
`define EBICS_BIT_CS1        1
`define EBICS_BIT_CS3        3
`define EBICS_BIT_CS4        4
`define EBICS_BIT_PULLUP     0
`define EBICS_ASSIGN_MASK    32'h0000001B
`define EBICS_CONFIG_MASK    32'h00000001
`define EBICS_RESET_VAL      32'h00000000
`define EBICS_ADDR_IO_BIT    23
`define EBICS_ADDR_ATTR_BIT  22
`define EBICS_BOOT_DBW_16    2'h1
`endif

// file: verilog/ebics_pkg.sv
// types shared by the chip select assignment block
package ebics_pkg;
   typedef struct packed {
      logic       cs0_route;
      logic       cs1_route;
      logic       cs3_route;
      logic       cs4_route;
      logic       pullup_off;
   } ebics_cfg_s;
   typedef enum logic [1:0] {EBICS_CTL_STATIC, EBICS_CTL_BURST, EBICS_CTL_SDRAM} ebics_ctl_e;
endpackage

// file: verilog/ebics_cfg_if.sv
// configuration carried from the register file to the pin mux
`timescale 1ns/1ps
`default_nettype none
interface ebics_cfg_if;
   ebics_pkg::ebics_cfg_s cfg;
   modport regs (output cfg);
   modport mux  (input cfg);
endinterface
`default_nettype wire

// file: verilog/ebics_pin_mux.sv
// registered pin multiplexer for chip selects and shared strobes
`timescale 1ns/1ps
`default_nettype none
`include "ebics_params.svh"
module ebics_pin_mux
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // configuration
   ebics_cfg_if.mux         cfg_if,
   // controller side
   input  wire logic        smc_cs0_n,
   input  wire logic        smc_cs1_n,
   input  wire logic        smc_cs3_n,
   input  wire logic        smc_cs4_n,
   input  wire logic        smc_cs5_n,
   input  wire logic        smc_cs6_n,
   input  wire logic        burst_cs0_n,
   input  wire logic        sdram_cs1_n,
   input  wire logic        smc_rd_n,
   input  wire logic        smc_wr_n,
   input  wire logic [25:0] smc_addr,
   input  wire logic        burst_flash_advance,
   input  wire logic        pad_ready_in,
   // pin side
   output logic             pin_cs0_n,
   output logic             pin_cs1_n,
   output logic             pin_cs3_n,
   output logic             chip_select_four_n,
   output logic             chip_select_five_n,
   output logic             chip_select_six_n,
   output logic             nand_read_strobe,
   output logic             nand_write_strobe,
   output logic             ready_pad_oe,
   output logic             burst_flash_ready,
   output logic             card_io_mode,
   output logic             card_attr_sel
);
   typedef struct packed {
      logic cs0_n;
      logic cs1_n;
      logic cs3_n;
      logic cs4_n;
      logic cs5_n;
      logic cs6_n;
      logic nrd;
      logic nwr;
      logic oe;
      logic rdy;
      logic io;
      logic attr;
   } ebics_mux_s;
   ebics_mux_s st_reg;
   ebics_mux_s st_next;
   ebics_pkg::ebics_cfg_s c;
   assign c = cfg_if.cfg;
   always_comb
   begin
      st_next = st_reg;
      st_next.cs0_n = c.cs0_route ? burst_cs0_n : smc_cs0_n;
      st_next.cs1_n = c.cs1_route ? sdram_cs1_n : smc_cs1_n;
      st_next.cs3_n = smc_cs3_n;
      // nand strobes only follow the controller while chip select 3 is active
      if (c.cs3_route)
      begin
         st_next.nrd = smc_cs3_n | smc_rd_n;
         st_next.nwr = smc_cs3_n | smc_wr_n;
         st_next.oe  = 1'b1;
         st_next.rdy = 1'b1;
      end
      else
      begin
         st_next.nrd = 1'b1;
         st_next.nwr = burst_flash_advance;
         st_next.oe  = 1'b0;
         st_next.rdy = pad_ready_in;
      end
      st_next.cs4_n = smc_cs4_n;
      if (c.cs4_route)
      begin
         // card byte enables follow the card select waveform; only cs5 is gated by a0
         st_next.cs5_n = smc_cs4_n | smc_addr[0];
         st_next.cs6_n = smc_cs4_n;
         st_next.io    = smc_addr[`EBICS_ADDR_IO_BIT];
         st_next.attr  = smc_addr[`EBICS_ADDR_ATTR_BIT];
      end
      else
      begin
         st_next.cs5_n = smc_cs5_n;
         st_next.cs6_n = smc_cs6_n;
         st_next.io    = 1'b0;
         st_next.attr  = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '{cs0_n: 1'b1, cs1_n: 1'b1, cs3_n: 1'b1, cs4_n: 1'b1, cs5_n: 1'b1, cs6_n: 1'b1,
                     nrd: 1'b1, nwr: 1'b0, oe: 1'b0, rdy: 1'b0, io: 1'b0, attr: 1'b0};
      else
         st_reg <= st_next;
   end
   assign pin_cs0_n          = st_reg.cs0_n;
   assign pin_cs1_n          = st_reg.cs1_n;
   assign pin_cs3_n          = st_reg.cs3_n;
   assign chip_select_four_n = st_reg.cs4_n;
   assign chip_select_five_n = st_reg.cs5_n;
   assign chip_select_six_n  = st_reg.cs6_n;
   assign nand_read_strobe   = st_reg.nrd;
   assign nand_write_strobe  = st_reg.nwr;
   assign ready_pad_oe       = st_reg.oe;
   assign burst_flash_ready  = st_reg.rdy;
   assign card_io_mode       = st_reg.io;
   assign card_attr_sel      = st_reg.attr;

   // the edge after a reset release still shows reset levels, so skip it
   a_cs0_route_src: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> pin_cs0_n == $past(c.cs0_route ? burst_cs0_n : smc_cs0_n))
      else $error("chip select 0 not routed per assignment");
   a_cs1_route_src: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> pin_cs1_n == $past(c.cs1_route ? sdram_cs1_n : smc_cs1_n))
      else $error("chip select 1 not routed per assignment");
   a_nand_strobe_idle: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n && c.cs3_route && smc_cs3_n) |-> nand_read_strobe && nand_write_strobe)
      else $error("nand strobe active outside chip select 3");
   a_ready_pad_dir: assert property (@(posedge clk) disable iff (!rst_n)
      ready_pad_oe == $past(c.cs3_route))
      else $error("ready pad direction wrong");
   a_card_pins_owned: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n && c.cs4_route) |-> chip_select_six_n == $past(smc_cs4_n))
      else $error("card byte enable not following card select");
   a_card_io_mode: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n && c.cs4_route) |-> card_io_mode == $past(smc_addr[23]))
      else $error("card io mode not taken from address bit 23");
   a_cs5_plain: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n && !c.cs4_route) |-> chip_select_five_n == $past(smc_cs5_n))
      else $error("chip select 5 not passed through");
endmodule
`default_nettype wire

// file: verilog/ebics_top.sv
// chip select assignment and bus configuration registers with pin routing
`timescale 1ns/1ps
`default_nettype none
`include "ebics_params.svh"
module ebics_top
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [31:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // controller side
   input  wire logic        smc_cs0_n,
   input  wire logic        smc_cs1_n,
   input  wire logic        smc_cs3_n,
   input  wire logic        smc_cs4_n,
   input  wire logic        smc_cs5_n,
   input  wire logic        smc_cs6_n,
   input  wire logic        burst_cs0_n,
   input  wire logic        sdram_cs1_n,
   input  wire logic        smc_rd_n,
   input  wire logic        smc_wr_n,
   input  wire logic [25:0] smc_addr,
   input  wire logic        burst_flash_advance,
   input  wire logic        pad_ready_in,
   // pins and status
   output logic             pin_cs0_n,
   output logic             pin_cs1_n,
   output logic             pin_cs3_n,
   output logic             chip_select_four_n,
   output logic             chip_select_five_n,
   output logic             chip_select_six_n,
   output logic             nand_read_strobe,
   output logic             nand_write_strobe,
   output logic             ready_pad_oe,
   output logic             burst_flash_ready,
   output logic             card_io_mode,
   output logic             card_attr_sel,
   output logic             data_bus_pullup_off,
   output logic [1:0]       cs0_controller,
   output logic [1:0]       cs1_controller
);
   typedef struct packed {
      ebics_pkg::ebics_cfg_s cfg;
      logic [31:0]           rdata;
      logic                  pullup_off;
      logic [1:0]            cs0_ctl;
      logic [1:0]            cs1_ctl;
   } ebics_top_s;
   ebics_top_s st_reg;
   ebics_top_s st_next;
   logic       hit;
   logic [7:0] off;
   logic [31:0] assign_val;
   logic [31:0] config_val;
   ebics_cfg_if cfg_if ();
   assign hit = (reg_addr[31:8] == 24'(`EBICS_BASE_ADDR >> 8));
   // base-relative offset; the page compare above has already matched the upper bits
   assign off = 8'(reg_addr[7:0] - 8'(`EBICS_BASE_ADDR));
   assign assign_val = {27'h0, st_reg.cfg.cs4_route, st_reg.cfg.cs3_route, 1'b0,
                        st_reg.cfg.cs1_route, st_reg.cfg.cs0_route};
   assign config_val = {31'h0, st_reg.cfg.pullup_off};
   always_comb
   begin
      st_next = st_reg;
      st_next.rdata = 32'h0;
      if (hit && reg_wr)
      begin
         case (off)
            `EBICS_OFF_ASSIGN:
            begin
               st_next.cfg.cs0_route = reg_wdata[`EBICS_BIT_CS0];
               st_next.cfg.cs1_route = reg_wdata[`EBICS_BIT_CS1];
               st_next.cfg.cs3_route = reg_wdata[`EBICS_BIT_CS3];
               st_next.cfg.cs4_route = reg_wdata[`EBICS_BIT_CS4];
            end
            `EBICS_OFF_CONFIG: st_next.cfg.pullup_off = reg_wdata[`EBICS_BIT_PULLUP];
            default: st_next.cfg = st_reg.cfg;
         endcase
      end
      if (hit && reg_rd)
      begin
         case (off)
            `EBICS_OFF_ASSIGN: st_next.rdata = assign_val & `EBICS_ASSIGN_MASK;
            `EBICS_OFF_CONFIG: st_next.rdata = config_val & `EBICS_CONFIG_MASK;
            // read-only view of chip select 0 boot setup: byte select, 16-bit, cs-gated strobes
            `EBICS_OFF_BOOT:   st_next.rdata = {28'h0, 1'b1, `EBICS_BOOT_DBW_16, 1'b1};
            default:           st_next.rdata = 32'h0;
         endcase
      end
      st_next.pullup_off = st_next.cfg.pullup_off;
      st_next.cs0_ctl = st_next.cfg.cs0_route ? 2'(ebics_pkg::EBICS_CTL_BURST) : 2'(ebics_pkg::EBICS_CTL_STATIC);
      st_next.cs1_ctl = st_next.cfg.cs1_route ? 2'(ebics_pkg::EBICS_CTL_SDRAM) : 2'(ebics_pkg::EBICS_CTL_STATIC);
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign cfg_if.cfg = st_reg.cfg;
   ebics_pin_mux u_ebics_pin_mux
   (
      .clk                 (clk),
      .rst_n               (rst_n),
      .cfg_if              (cfg_if),
      .smc_cs0_n           (smc_cs0_n),
      .smc_cs1_n           (smc_cs1_n),
      .smc_cs3_n           (smc_cs3_n),
      .smc_cs4_n           (smc_cs4_n),
      .smc_cs5_n           (smc_cs5_n),
      .smc_cs6_n           (smc_cs6_n),
      .burst_cs0_n         (burst_cs0_n),
      .sdram_cs1_n         (sdram_cs1_n),
      .smc_rd_n            (smc_rd_n),
      .smc_wr_n            (smc_wr_n),
      .smc_addr            (smc_addr),
      .burst_flash_advance (burst_flash_advance),
      .pad_ready_in        (pad_ready_in),
      .pin_cs0_n           (pin_cs0_n),
      .pin_cs1_n           (pin_cs1_n),
      .pin_cs3_n           (pin_cs3_n),
      .chip_select_four_n  (chip_select_four_n),
      .chip_select_five_n  (chip_select_five_n),
      .chip_select_six_n   (chip_select_six_n),
      .nand_read_strobe    (nand_read_strobe),
      .nand_write_strobe   (nand_write_strobe),
      .ready_pad_oe        (ready_pad_oe),
      .burst_flash_ready   (burst_flash_ready),
      .card_io_mode        (card_io_mode),
      .card_attr_sel       (card_attr_sel)
   );
   assign reg_rdata           = st_reg.rdata;
   assign data_bus_pullup_off = st_reg.pullup_off;
   assign cs0_controller      = st_reg.cs0_ctl;
   assign cs1_controller      = st_reg.cs1_ctl;

   // register file checks; read data answer one cycle after the strobe
   sequence s_assign_write;
      hit && reg_wr && off == 8'h00;
   endsequence
   sequence s_assign_read;
      hit && reg_rd && off == 8'h00;
   endsequence
   sequence s_config_write;
      hit && reg_wr && off == 8'h04;
   endsequence
   sequence s_config_read;
      hit && reg_rd && off == 8'h04;
   endsequence
   sequence s_boot_read;
      hit && reg_rd && off == 8'h10;
   endsequence
   a_assign_readback: assert property (@(posedge clk) disable iff (!rst_n)
      s_assign_write ##1 s_assign_read |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000001B))
      else $error("assignment register readback mismatch");
   a_config_readback: assert property (@(posedge clk) disable iff (!rst_n)
      s_config_write ##1 s_config_read |=> reg_rdata == ($past(reg_wdata, 2) & 32'h00000001))
      else $error("configuration register readback mismatch");
   a_pullup_follow: assert property (@(posedge clk) disable iff (!rst_n)
      s_config_write |=> data_bus_pullup_off == $past(reg_wdata[0]))
      else $error("pull-up control not updated");
   a_pullup_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(hit && reg_wr && off == 8'h04) |=> $stable(data_bus_pullup_off))
      else $error("pull-up control changed without a write");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      hit && reg_rd && (off == 8'h08 || off == 8'h0C) |=> reg_rdata == 32'h0)
      else $error("reserved offset reads non-zero");
   a_assign_rsvd_bits: assert property (@(posedge clk) disable iff (!rst_n)
      s_assign_read |=> (reg_rdata & 32'hFFFFFFE4) == 32'h0)
      else $error("assignment register reserved bits read non-zero");
   a_config_rsvd_bits: assert property (@(posedge clk) disable iff (!rst_n)
      s_config_read |=> reg_rdata[31:1] == 31'h0)
      else $error("configuration register reserved bits read non-zero");
   a_boot_readback: assert property (@(posedge clk) disable iff (!rst_n)
      s_boot_read |=> reg_rdata == 32'h0000000B)
      else $error("chip select 0 boot setup reads wrong");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !(hit && reg_rd) |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   // a write anywhere but the two live offsets must leave routing as it was
   a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(hit && reg_wr && (off == 8'h00 || off == 8'h04)) |=> $stable(st_reg.cfg))
      else $error("configuration changed without a live write");
   a_off_page_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && !hit |=> $stable(st_reg.cfg))
      else $error("write outside the register page took effect");
   a_cs0_ctl_burst: assert property (@(posedge clk) disable iff (!rst_n)
      s_assign_write |=> cs0_controller == ($past(reg_wdata[0]) ? 2'h1 : 2'h0))
      else $error("chip select 0 controller not updated");
   a_cs1_ctl_sdram: assert property (@(posedge clk) disable iff (!rst_n)
      s_assign_write |=> cs1_controller == ($past(reg_wdata[1]) ? 2'h2 : 2'h0))
      else $error("chip select 1 controller not updated");
   a_ctl_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(hit && reg_wr && off == 8'h00) |=> $stable(cs0_controller) && $stable(cs1_controller))
      else $error("controller selection changed without a write");
   a_cs3_route_write: assert property (@(posedge clk) disable iff (!rst_n)
      s_assign_write |=> st_reg.cfg.cs3_route == $past(reg_wdata[3]))
      else $error("chip select 3 assignment not stored");
   a_cs4_route_write: assert property (@(posedge clk) disable iff (!rst_n)
      s_assign_write |=> st_reg.cfg.cs4_route == $past(reg_wdata[4]))
      else $error("chip select 4 assignment not stored");
endmodule
`default_nettype wire

// file: verif/ebics_ext_mem.sv
// far-side model: burst flash ready line sharing the nand read strobe pad
`timescale 1ns/1ps
`default_nettype none
module ebics_ext_mem
(
   // pad control from the block
   input  wire logic ready_pad_oe,
   input  wire logic nand_read_strobe,
   // flash state set by the bench
   input  wire logic flash_busy,
   // resolved pad level
   output logic      pad_level
);
   // flash drives ready only while the block leaves the pad as an input
   always_comb
   begin
      if (ready_pad_oe)
         pad_level = nand_read_strobe;
      else
         pad_level = !flash_busy;
   end
endmodule
`default_nettype wire

// file: verif/ebics_top_tb.sv
// self-checking bench for the chip select assignment block
`timescale 1ns/1ps
`default_nettype none
`include "ebics_params.svh"
module ebics_top_tb;
   logic        clk = 1'b0;
   logic        rst_n;
   logic [31:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [11:0] drv;
   logic [25:0] smc_addr;
   logic        pad_ready_in;
   logic        pin_cs0_n, pin_cs1_n, pin_cs3_n, cs4_n, cs5_n, cs6_n;
   logic        rd_stb, wr_stb, pad_oe, bf_rdy, io_mode, attr_sel, pu_off;
   logic [1:0]  cs0_ctl, cs1_ctl;
   logic [31:0] seed = 32'hC5D1;
   int          err_count = 0;
   int          n_checks = 0;

   always #4 clk = ~clk;

   ebics_top u_ebics_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smc_cs0_n(drv[0]), .smc_cs1_n(drv[1]),
      .smc_cs3_n(drv[2]), .smc_cs4_n(drv[3]), .smc_cs5_n(drv[4]), .smc_cs6_n(drv[5]),
      .burst_cs0_n(drv[6]), .sdram_cs1_n(drv[7]), .smc_rd_n(drv[8]), .smc_wr_n(drv[9]),
      .smc_addr(smc_addr), .burst_flash_advance(drv[10]), .pad_ready_in(pad_ready_in),
      .pin_cs0_n(pin_cs0_n), .pin_cs1_n(pin_cs1_n), .pin_cs3_n(pin_cs3_n), .chip_select_four_n(cs4_n),
      .chip_select_five_n(cs5_n), .chip_select_six_n(cs6_n), .nand_read_strobe(rd_stb),
      .nand_write_strobe(wr_stb), .ready_pad_oe(pad_oe), .burst_flash_ready(bf_rdy),
      .card_io_mode(io_mode), .card_attr_sel(attr_sel), .data_bus_pullup_off(pu_off),
      .cs0_controller(cs0_ctl), .cs1_controller(cs1_ctl));

   ebics_ext_mem u_ebics_ext_mem (.ready_pad_oe(pad_oe), .nand_read_strobe(rd_stb),
      .flash_busy(drv[11]), .pad_level(pad_ready_in));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // read data is only valid in the single cycle after the strobe
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // write then read back with no idle cycle between the strobes
   task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge clk);
      reg_rd    <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (10000) @(posedge clk);
      err_count++;
      conclude();
   end

   initial
   begin
      logic [4:0]  csa;
      logic [11:0] x;
      logic [25:0] a;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      drv = 12'hFFF;
      smc_addr = 26'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rchk(`EBICS_BASE_ADDR, 32'h0);
      rchk(`EBICS_BASE_ADDR + 32'h4, 32'h0);
      rchk(`EBICS_BASE_ADDR + 32'h10, 32'h0000000B);
      chk(cs0_ctl, 32'h0);
      $display("test reset done");
      wr(`EBICS_BASE_ADDR + 32'h8, 32'hFFFFFFFF);
      wr(`EBICS_BASE_ADDR + 32'hC, 32'hFFFFFFFF);
      wr(32'hFFFFFE60, 32'hFFFFFFFF);
      wr(`EBICS_BASE_ADDR + 32'h10, 32'h0);
      rchk(`EBICS_BASE_ADDR, 32'h0);
      rchk(`EBICS_BASE_ADDR + 32'h8, 32'h0);
      rchk(`EBICS_BASE_ADDR + 32'hC, 32'h0);
      rchk(`EBICS_BASE_ADDR + 32'h10, 32'h0000000B);
      $display("test reserved done");
      for (int i = 0; i < 16; i++)
      begin
         seed = xs(seed);
         wr_rd(`EBICS_BASE_ADDR, seed, seed & `EBICS_ASSIGN_MASK);
         rchk(`EBICS_BASE_ADDR, seed & `EBICS_ASSIGN_MASK);
         wr_rd(`EBICS_BASE_ADDR + 32'h4, ~seed, ~seed & `EBICS_CONFIG_MASK);
         rchk(`EBICS_BASE_ADDR + 32'h4, ~seed & `EBICS_CONFIG_MASK);
      end
      $display("test registers done");
      // sdram on cs1 assumes software set 32-bit width and upper data pins
      // card reset, irq and detect sit on general lines outside this block
      for (int c = 0; c < 64; c++)
      begin
         csa = c[4:0];
         wr(`EBICS_BASE_ADDR, {27'h0, csa});
         wr(`EBICS_BASE_ADDR + 32'h4, {31'h0, c[5]});
         rchk(`EBICS_BASE_ADDR, {27'h0, csa} & `EBICS_ASSIGN_MASK);
         for (int v = 0; v < 8; v++)
         begin
            seed = xs(seed);
            x = seed[11:0];
            if (csa[4])
               x[5:4] = 2'h3;
            seed = xs(seed);
            a = seed[25:0];
            @(posedge clk);
            drv <= x;
            smc_addr <= a;
            repeat (2) @(posedge clk);
            #1;
            chk(pin_cs0_n, csa[0] ? x[6] : x[0]);
            chk(cs0_ctl, {31'h0, csa[0]});
            chk(pin_cs1_n, csa[1] ? x[7] : x[1]);
            chk(cs1_ctl, csa[1] ? 32'h2 : 32'h0);
            chk(pin_cs3_n, x[2]);
            chk(cs4_n, x[3]);
            chk(cs5_n, csa[4] ? (x[3] | a[0]) : x[4]);
            chk(cs6_n, csa[4] ? x[3] : x[5]);
            chk(pad_oe, csa[3]);
            chk(wr_stb, csa[3] ? (x[9] | x[2]) : x[10]);
            if (csa[3])
               chk(rd_stb, x[8] | x[2]);
            chk(bf_rdy, csa[3] ? 32'h1 : {31'h0, !x[11]});
            chk(io_mode, csa[4] & a[23]);
            chk(attr_sel, csa[4] & a[22]);
            chk(pu_off, c[5]);
         end
      end
      $display("test routing done");
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rchk(`EBICS_BASE_ADDR, 32'h0);
      rchk(`EBICS_BASE_ADDR + 32'h4, 32'h0);
      chk(pu_off, 32'h0);
      chk(cs0_ctl, 32'h0);
      $display("test second reset done");
      conclude();
   end
endmodule
`default_nettype wire
